/* pkg/fmic_pkg.sv */
// fmic_pkg: register map, field positions, reset values and sleep encodings
// for the front end mode and input configuration register slice.
// assumes a 32-bit apb bus with word-aligned registers.
package fmic_pkg;
    // printed offsets are register indices; byte address is four times it
    localparam logic [7:0] FMIC_IDX_SYSCTL = 8'h0F;
    localparam logic [7:0] FMIC_IDX_OPERATING_MODE = 8'h10;
    localparam logic [7:0] FMIC_IDX_INSLEEP = 8'h20;
    localparam logic [7:0] FMIC_IDX_INCFG = 8'h21;
    localparam logic [15:0] FMIC_SYSCTL_RST = 16'h0000;
    localparam logic [15:0] FMIC_OPERATING_MODE_RST = 16'h0000;
    localparam logic [15:0] FMIC_INSLEEP_RST = 16'h0000;
    localparam logic [15:0] FMIC_INCFG_RST = 16'h0000;
    // writable masks; all other bits are reserved, read zero
    localparam logic [15:0] FMIC_SYSCTL_MASK = 16'h0007;
    localparam logic [15:0] FMIC_OPERATING_MODE_MASK = 16'h0F01;
    localparam logic [15:0] FMIC_INSLEEP_MASK = 16'hF00F;
    localparam logic [15:0] FMIC_INCFG_MASK = 16'h00F9;
    localparam int FMIC_SLOW_EN_BIT = 0;
    localparam int FMIC_FAST_EN_BIT = 1;
    localparam int FMIC_SEL_BIT = 2;
    localparam int FMIC_RUN_BIT = 0;
    localparam int FMIC_SLOT_LSB = 8;
    localparam int FMIC_PAIRB_LSB = 12;
    localparam int FMIC_PAIRA_LSB = 0;
    localparam int FMIC_BIAS2_LSB = 6;
    localparam int FMIC_BIAS1_LSB = 4;
    localparam int FMIC_PAIRB_DIFF_BIT = 3;
    localparam int FMIC_PAIRA_DIFF_BIT = 0;
    localparam int FMIC_NUM_SLOTS = 12;
    // per-input connection during sleep
    typedef enum logic [1:0] {
        FMIC_CONN_FLOAT = 2'h0,
        FMIC_CONN_BIAS1 = 2'h1,
        FMIC_CONN_BIAS2 = 2'h2
    } fmic_conn_t;
    // bias output sleep level
    typedef enum logic [1:0] {
        FMIC_BIAS_SUPPLY = 2'h0,
        FMIC_BIAS_GROUND = 2'h1,
        FMIC_BIAS_FLOAT = 2'h2
    } fmic_bias_t;
endpackage

/* design/fmic_pair_sleep.sv */
// fmic_pair_sleep: decodes one input pair's sleep code into switch states.
// assumes code and differential flag come from registers.
`timescale 1ns/1ps
module fmic_pair_sleep
    import fmic_pkg::*;
(
    input wire logic [3:0] code,
    input wire logic diff,
    output fmic_conn_t conn_first,
    output fmic_conn_t conn_second,
    output logic short_pair
);
    always_comb
    begin
        conn_first = FMIC_CONN_FLOAT;
        conn_second = FMIC_CONN_FLOAT;
        short_pair = 1'b0;
        case (code)
            4'h1: short_pair = diff;
            4'h2:
            begin
                conn_first = FMIC_CONN_BIAS1;
                conn_second = FMIC_CONN_BIAS1;
                short_pair = diff;
            end
            4'h3:
            begin
                conn_first = FMIC_CONN_BIAS2;
                conn_second = FMIC_CONN_BIAS2;
                short_pair = diff;
            end
            4'h4: conn_first = FMIC_CONN_BIAS1;
            4'h5:
            begin
                conn_first = FMIC_CONN_BIAS1;
                conn_second = FMIC_CONN_BIAS2;
            end
            4'h6: conn_first = FMIC_CONN_BIAS2;
            4'h7:
            begin
                conn_first = FMIC_CONN_BIAS2;
                conn_second = FMIC_CONN_BIAS1;
            end
            4'h8: conn_second = FMIC_CONN_BIAS1;
            4'h9: conn_second = FMIC_CONN_BIAS2;
            // undefined codes leave both inputs floating
            default: short_pair = 1'b0;
        endcase
    end
endmodule

/* design/fmic_slot_seq.sv */
// fmic_slot_seq: steps through enabled time slots while running.
// assumes one slot step per clock; real slot timing lives elsewhere.
`timescale 1ns/1ps
module fmic_slot_seq
    import fmic_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic run,
    input wire logic [3:0] last_slot,
    output logic [3:0] slot
);
    logic [3:0] next_slot;
    always_comb
    begin
        next_slot = slot;
        if (!run)
            next_slot = 4'h0;
        else if (slot >= last_slot)
            next_slot = 4'h0;
        else
            next_slot = slot + 4'h1;
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            slot <= 4'h0;
        else
            slot <= next_slot;
    end
endmodule

/* design/fmic_regs.sv */
// fmic_regs: apb register slice for oscillator enables, operating mode and
// input sleep/pairing configuration of the front end.
// assumes an apb master on pclk; zero wait states.
// Operation
// - system control bit 1 powers the fast low frequency oscillator.
// - system control bit 0 powers the slow low frequency oscillator.
// - system control bit 2 selects slow (0) or fast (1) oscillator.
// - slot count field 11:8 runs slots A up to code plus one.
// - run select bit 0 gives standby at zero, go at one, resets zero.
// - pair b sleep code sits in 15:12; 0 floats, 1 shorts if differential.
// - codes 2 and 3 tie both inputs to bias one or two, short if diff.
// - codes 4 to 9 connect each input individually.
// - pair a sleep code sits in 3:0 with the same encoding.
// - pair a code 1 shorts only while pair a is differential.
// - bias two sleep field 7:6: supply, ground, floating.
// - bias one sleep field 5:4 uses the same encoding.
// - input config bit 3 makes inputs seven/eight differential.
// - input config bit 0 makes inputs one/two differential.
`timescale 1ns/1ps
module fmic_regs
    import fmic_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic fast_lf_osc_enable,
    output logic slow_lf_osc_enable,
    output logic lf_osc_select,
    output logic run_select,
    output logic [11:0] slot_enable,
    output logic [3:0] active_slot,
    output fmic_conn_t input_one_conn,
    output fmic_conn_t input_two_conn,
    output logic pair_a_short,
    output fmic_conn_t input_seven_conn,
    output fmic_conn_t input_eight_conn,
    output logic pair_b_short,
    output fmic_bias_t bias_out_one,
    output fmic_bias_t bias_out_two,
    output logic pair_a_differential,
    output logic pair_b_differential
);
    import fmic_pkg::*;

    logic [15:0] system_control;
    logic [15:0] operating_mode;
    logic [15:0] input_sleep_state;
    logic [15:0] input_configuration;
    logic [15:0] next_system_control;
    logic [15:0] next_operating_mode;
    logic [15:0] next_input_sleep_state;
    logic [15:0] next_input_configuration;
    logic [31:0] next_prdata;
    logic next_pslverr;
    logic [11:0] next_slot_enable;
    logic [3:0] seq_slot;
    fmic_conn_t a1, a2, b7, b8;
    logic a_sh, b_sh;
    logic [31:0] stage_a;
    logic [31:0] stage_b;

    // index from byte address; misaligned or high addresses are unmapped
    function automatic logic hit(input logic [31:0] addr,
                                 input logic [7:0] idx);
        hit = (addr[1:0] == 2'h0) && (addr[31:10] == 22'h0) &&
              (addr[9:2] == idx);
    endfunction

    function automatic logic [15:0] merge(input logic [15:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0] be,
                                          input logic [15:0] mask);
        logic [15:0] v;
        v = old;
        if (be[0])
            v[7:0] = wd[7:0];
        if (be[1])
            v[15:8] = wd[15:8];
        merge = v & mask;
    endfunction

    function automatic fmic_bias_t bias_dec(input logic [1:0] f);
        case (f)
            2'h0: bias_dec = FMIC_BIAS_SUPPLY;
            2'h1: bias_dec = FMIC_BIAS_GROUND;
            // code 3 undefined; treated as floating
            default: bias_dec = FMIC_BIAS_FLOAT;
        endcase
    endfunction

    wire logic access = psel && penable;
    wire logic wr = access && pwrite;
    wire logic mapped = hit(paddr, FMIC_IDX_SYSCTL) ||
        hit(paddr, FMIC_IDX_OPERATING_MODE) || hit(paddr, FMIC_IDX_INSLEEP) ||
        hit(paddr, FMIC_IDX_INCFG);

    always_comb
    begin
        next_system_control = system_control;
        next_operating_mode = operating_mode;
        next_input_sleep_state = input_sleep_state;
        next_input_configuration = input_configuration;
        if (wr && hit(paddr, FMIC_IDX_SYSCTL))
            next_system_control = merge(system_control, pwdata, pstrb,
                                        FMIC_SYSCTL_MASK);
        if (wr && hit(paddr, FMIC_IDX_OPERATING_MODE))
            next_operating_mode = merge(operating_mode, pwdata, pstrb,
                                        FMIC_OPERATING_MODE_MASK);
        if (wr && hit(paddr, FMIC_IDX_INSLEEP))
            next_input_sleep_state = merge(input_sleep_state, pwdata,
                pstrb, FMIC_INSLEEP_MASK);
        if (wr && hit(paddr, FMIC_IDX_INCFG))
            next_input_configuration = merge(input_configuration, pwdata,
                pstrb, FMIC_INCFG_MASK);
    end

    // read data set up in the setup cycle so it is registered at access
    always_comb
    begin
        next_prdata = 32'h0;
        next_pslverr = 1'b0;
        if (psel && !penable && !pwrite)
        begin
            if (hit(paddr, FMIC_IDX_SYSCTL))
                next_prdata = {16'h0, system_control};
            else if (hit(paddr, FMIC_IDX_OPERATING_MODE))
                next_prdata = {16'h0, operating_mode};
            else if (hit(paddr, FMIC_IDX_INSLEEP))
                next_prdata = {16'h0, input_sleep_state};
            else if (hit(paddr, FMIC_IDX_INCFG))
                next_prdata = {16'h0, input_configuration};
        end
        if (psel && !penable)
            next_pslverr = !mapped;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            system_control <= FMIC_SYSCTL_RST;
            operating_mode <= FMIC_OPERATING_MODE_RST;
            input_sleep_state <= FMIC_INSLEEP_RST;
            input_configuration <= FMIC_INCFG_RST;
        end
        else
        begin
            system_control <= next_system_control;
            operating_mode <= next_operating_mode;
            input_sleep_state <= next_input_sleep_state;
            input_configuration <= next_input_configuration;
        end
    end

    // pready high in the access cycle: registered from the setup cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            prdata <= next_prdata;
            pready <= psel && !penable;
            pslverr <= next_pslverr;
        end
    end

    fmic_pair_sleep u_pair_a (
        .code(input_sleep_state[FMIC_PAIRA_LSB +: 4]),
        .diff(input_configuration[FMIC_PAIRA_DIFF_BIT]),
        .conn_first(a1),
        .conn_second(a2),
        .short_pair(a_sh)
    );
    fmic_pair_sleep u_pair_b (
        .code(input_sleep_state[FMIC_PAIRB_LSB +: 4]),
        .diff(input_configuration[FMIC_PAIRB_DIFF_BIT]),
        .conn_first(b7),
        .conn_second(b8),
        .short_pair(b_sh)
    );
    fmic_slot_seq u_seq (
        .pclk(pclk),
        .presetn(presetn),
        .run(operating_mode[FMIC_RUN_BIT]),
        .last_slot(operating_mode[FMIC_SLOT_LSB +: 4]),
        .slot(seq_slot)
    );

    genvar g;
    generate
        for (g = 0; g < FMIC_NUM_SLOTS; g++)
        begin : g_slot
            // slot g runs when code >= g
            assign next_slot_enable[g] = operating_mode[FMIC_RUN_BIT] &&
                (operating_mode[FMIC_SLOT_LSB +: 4] >= 4'(g));
        end
    endgenerate

    // output staging: every top output from a flip-flop
    always_comb
    begin
        stage_a = 32'h0;
        stage_a[0] = system_control[FMIC_FAST_EN_BIT];
        stage_a[1] = system_control[FMIC_SLOW_EN_BIT];
        stage_a[2] = system_control[FMIC_SEL_BIT];
        stage_a[3] = operating_mode[FMIC_RUN_BIT];
        stage_a[15:4] = next_slot_enable;
        stage_a[19:16] = seq_slot;
        stage_a[20] = input_configuration[FMIC_PAIRA_DIFF_BIT];
        stage_a[21] = input_configuration[FMIC_PAIRB_DIFF_BIT];
        stage_b = 32'h0;
        stage_b[1:0] = a1;
        stage_b[3:2] = a2;
        stage_b[4] = a_sh;
        stage_b[6:5] = b7;
        stage_b[8:7] = b8;
        stage_b[9] = b_sh;
        stage_b[11:10] = bias_dec(
            input_configuration[FMIC_BIAS1_LSB +: 2]);
        stage_b[13:12] = bias_dec(
            input_configuration[FMIC_BIAS2_LSB +: 2]);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            fast_lf_osc_enable <= 1'b0;
            slow_lf_osc_enable <= 1'b0;
            lf_osc_select <= 1'b0;
            run_select <= 1'b0;
            slot_enable <= 12'h000;
            active_slot <= 4'h0;
            pair_a_differential <= 1'b0;
            pair_b_differential <= 1'b0;
            input_one_conn <= FMIC_CONN_FLOAT;
            input_two_conn <= FMIC_CONN_FLOAT;
            pair_a_short <= 1'b0;
            input_seven_conn <= FMIC_CONN_FLOAT;
            input_eight_conn <= FMIC_CONN_FLOAT;
            pair_b_short <= 1'b0;
            bias_out_one <= FMIC_BIAS_SUPPLY;
            bias_out_two <= FMIC_BIAS_SUPPLY;
        end
        else
        begin
            fast_lf_osc_enable <= stage_a[0];
            slow_lf_osc_enable <= stage_a[1];
            lf_osc_select <= stage_a[2];
            run_select <= stage_a[3];
            slot_enable <= stage_a[15:4];
            active_slot <= stage_a[19:16];
            pair_a_differential <= stage_a[20];
            pair_b_differential <= stage_a[21];
            input_one_conn <= fmic_conn_t'(stage_b[1:0]);
            input_two_conn <= fmic_conn_t'(stage_b[3:2]);
            pair_a_short <= stage_b[4];
            input_seven_conn <= fmic_conn_t'(stage_b[6:5]);
            input_eight_conn <= fmic_conn_t'(stage_b[8:7]);
            pair_b_short <= stage_b[9];
            bias_out_one <= fmic_bias_t'(stage_b[11:10]);
            bias_out_two <= fmic_bias_t'(stage_b[13:12]);
        end
    end

    fast_osc_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(system_control[FMIC_FAST_EN_BIT]) |=> fast_lf_osc_enable)
        else $error("fast oscillator enable not followed");
    slow_osc_a: assert property (@(posedge pclk) disable iff (!presetn)
        slow_lf_osc_enable == $past(system_control[FMIC_SLOW_EN_BIT]))
        else $error("slow oscillator enable mismatch");
    osc_select_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr && hit(paddr, FMIC_IDX_SYSCTL) && pstrb[0]
        |=> ##1 lf_osc_select == $past(pwdata[FMIC_SEL_BIT], 2))
        else $error("oscillator select not written");
    slot_count_a: assert property (@(posedge pclk) disable iff (!presetn)
        run_select |-> slot_enable[0] &&
        (slot_enable[11] == (operating_mode[11:8] == 4'hB) ||
         $changed(operating_mode)))
        else $error("slot enable mismatch");
    standby_a: assert property (@(posedge pclk) disable iff (!presetn)
        !run_select && !$past(run_select) |-> slot_enable == 12'h000)
        else $error("slots enabled in standby");
    pair_b_short_a: assert property (@(posedge pclk) disable iff (!presetn)
        $stable(input_sleep_state) && $stable(input_configuration) &&
        input_sleep_state[15:12] == 4'h1 && !input_configuration[3]
        |=> !pair_b_short)
        else $error("pair b shorted while single ended");
    pair_a_short_a: assert property (@(posedge pclk) disable iff (!presetn)
        $stable(input_sleep_state) && $stable(input_configuration) &&
        input_sleep_state[3:0] == 4'h1 && input_configuration[0]
        |=> pair_a_short)
        else $error("pair a short missing");
    bias_two_a: assert property (@(posedge pclk) disable iff (!presetn)
        $stable(input_configuration) && input_configuration[7:6] == 2'h1
        |=> bias_out_two == FMIC_BIAS_GROUND)
        else $error("bias two not grounded");
    reserved_a: assert property (@(posedge pclk) disable iff (!presetn)
        operating_mode[15:12] == 4'h0 && operating_mode[7:1] == 7'h0 &&
        input_sleep_state[11:4] == 8'h0 && input_configuration[2:1] == 2'h0)
        else $error("reserved bit set");
endmodule

/* sim/fmic_regs_tb_top.sv */
// fmic_regs_tb_top: self-checking bench for the mode and input config slice.
// assumes zero-wait apb slave; outputs settle within three clocks of a write.
`timescale 1ns/1ps
module fmic_regs_tb_top;
    import fmic_pkg::*;
    localparam logic [31:0] a_sys = {22'h0, FMIC_IDX_SYSCTL, 2'b00};
    localparam logic [31:0] a_mode = {22'h0, FMIC_IDX_OPERATING_MODE, 2'b00};
    localparam logic [31:0] a_slp = {22'h0, FMIC_IDX_INSLEEP, 2'b00};
    localparam logic [31:0] a_cfg = {22'h0, FMIC_IDX_INCFG, 2'b00};
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [31:0] paddr, pwdata, prdata;
    logic [3:0] pstrb, act_slot;
    logic fast_en, slow_en, osc_sel, run_sel, short_a, short_b, diff_a, diff_b;
    logic [11:0] slot_en;
    fmic_conn_t c1, c2, c7, c8;
    fmic_bias_t b1, b2;
    logic [33:0] notes[$];
    logic [33:0] note;
    int bad_count, n_tests;

    fmic_regs i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .fast_lf_osc_enable(fast_en), .slow_lf_osc_enable(slow_en),
        .lf_osc_select(osc_sel), .run_select(run_sel), .slot_enable(slot_en),
        .active_slot(act_slot), .input_one_conn(c1), .input_two_conn(c2),
        .pair_a_short(short_a), .input_seven_conn(c7),
        .input_eight_conn(c8), .pair_b_short(short_b), .bias_out_one(b1),
        .bias_out_two(b2), .pair_a_differential(diff_a),
        .pair_b_differential(diff_b));

    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        n_tests++;
        if (g !== e)
        begin
            bad_count++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask

    // one apb transfer; the expected answer is queued for the monitor
    task automatic apb(input logic wr, input logic [31:0] a,
                       input logic [31:0] d, input logic [3:0] st,
                       input logic [31:0] e, input logic err);
        int n;
        @(posedge pclk);
        notes.push_back({wr, err, e});
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= st;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 16);
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1)
        begin
            bad_count++;
            $display("FAIL pready expected 1 seen %b", pready);
            wrap_up();
        end
    endtask

    task automatic wreg(input logic [31:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 4'hF, 32'h0, 1'b0);
    endtask

    task automatic rreg(input logic [31:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0, 4'hF, e, 1'b0);
    endtask

    task automatic settle;
        repeat (3) @(posedge pclk);
    endtask

    function automatic logic [4:0] sleep_exp(input logic [3:0] c,
                                             input logic df);
        logic [3:0] fs;
        case (c)
            4'h2: fs = {FMIC_CONN_BIAS1, FMIC_CONN_BIAS1};
            4'h3: fs = {FMIC_CONN_BIAS2, FMIC_CONN_BIAS2};
            4'h4: fs = {FMIC_CONN_BIAS1, FMIC_CONN_FLOAT};
            4'h5: fs = {FMIC_CONN_BIAS1, FMIC_CONN_BIAS2};
            4'h6: fs = {FMIC_CONN_BIAS2, FMIC_CONN_FLOAT};
            4'h7: fs = {FMIC_CONN_BIAS2, FMIC_CONN_BIAS1};
            4'h8: fs = {FMIC_CONN_FLOAT, FMIC_CONN_BIAS1};
            4'h9: fs = {FMIC_CONN_FLOAT, FMIC_CONN_BIAS2};
            default: fs = {FMIC_CONN_FLOAT, FMIC_CONN_FLOAT};
        endcase
        return {fs, df && (c == 4'h1 || c == 4'h2 || c == 4'h3)};
    endfunction

    function automatic logic [1:0] bias_exp(input logic [1:0] c);
        if (c == 2'h0)
            return FMIC_BIAS_SUPPLY;
        if (c == 2'h1)
            return FMIC_BIAS_GROUND;
        return FMIC_BIAS_FLOAT;
    endfunction

    // compares every completed transfer against the oldest queued note
    always @(posedge pclk)
    begin
        if (presetn && psel && penable && pready === 1'b1 && notes.size() > 0)
        begin
            note = notes.pop_front();
            chk("pslverr", {31'h0, note[32]}, {31'h0, pslverr});
            if (note[33] === 1'b0)
                chk("prdata", note[31:0], prdata);
        end
    end

    task automatic all_zero;
        chk("ctrl", 32'h0,
            {fast_en, slow_en, osc_sel, run_sel, slot_en});
        chk("pins", 32'h0,
            {c1, c2, c7, c8, b1, b2, short_a, short_b});
        rreg(a_sys, {16'h0, FMIC_SYSCTL_RST});
        rreg(a_mode, {16'h0, FMIC_OPERATING_MODE_RST});
        rreg(a_slp, {16'h0, FMIC_INSLEEP_RST});
        rreg(a_cfg, {16'h0, FMIC_INCFG_RST});
    endtask

    initial
    begin
        int k, mx;
        logic [31:0] d, s;
        logic [3:0] ca, cb;
        logic da, db;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h0;
        pwdata = 32'h0;
        pstrb = 4'h0;
        bad_count = 0;
        n_tests = 0;
        void'($urandom(67));
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        all_zero();
        for (k = 0; k < 8; k++)
        begin
            d = ($urandom & 32'hFFFF_FFF8) | k;
            wreg(a_sys, d);
            rreg(a_sys, d & {16'h0, FMIC_SYSCTL_MASK});
            settle();
            chk("osc", k,
                {osc_sel, fast_en, slow_en});
        end
        // both oscillators stay enabled while slots run
        wreg(a_sys, 32'h3);
        for (k = 0; k < 24; k++)
        begin
            ca = 4'(k % 12);
            da = (k >= 12);
            d = ($urandom & ~32'h0F01) | {ca, 7'h0, da};
            wreg(a_mode, d);
            rreg(a_mode, d & {16'h0, FMIC_OPERATING_MODE_MASK});
            settle();
            s = da ? ((32'h2 << ca) - 32'h1) : 32'h0;
            chk("slots", s, {20'h0, slot_en});
            chk("run", {31'h0, da}, {31'h0, run_sel});
            if (da)
            begin
                mx = 0;
                repeat (30)
                begin
                    @(posedge pclk);
                    if (act_slot > mx)
                        mx = act_slot;
                end
                chk("last_slot", ca, mx);
            end
        end
        wreg(a_mode, 32'h0);
        apb(1'b1, a_mode, 32'h0B01, 4'h1, 32'h0, 1'b0);
        rreg(a_mode, 32'h0001);
        apb(1'b1, a_mode, 32'h0B00, 4'h2, 32'h0, 1'b0);
        rreg(a_mode, 32'h0B01);
        for (k = 0; k < 20; k++)
        begin
            ca = 4'(k % 10);
            cb = 4'((k + 3) % 10);
            da = (k >= 10);
            db = ~da;
            d = ($urandom & 32'hFFFF_FF06) |
                {2'((k >> 2) & 3), 2'(k & 3), db, 2'b0, da};
            wreg(a_cfg, d);
            rreg(a_cfg, d & {16'h0, FMIC_INCFG_MASK});
            s = ($urandom & ~32'hF00F) | {cb, 8'h0, ca};
            wreg(a_slp, s);
            rreg(a_slp, s & {16'h0, FMIC_INSLEEP_MASK});
            settle();
            chk("pair_a", sleep_exp(ca, da),
                {c1, c2, short_a});
            chk("pair_b", sleep_exp(cb, db),
                {c7, c8, short_b});
            chk("diff", {da, db}, {diff_a, diff_b});
            chk("bias", {bias_exp(d[7:6]), bias_exp(d[5:4])},
                {b2, b1});
        end
        apb(1'b1, 32'h44, $urandom, 4'hF, 32'h0, 1'b1);
        apb(1'b0, 32'h44, 32'h0, 4'hF, 32'h0, 1'b1);
        apb(1'b1, a_mode + 32'h2, 32'h0001, 4'hF, 32'h0, 1'b1);
        rreg(a_mode, 32'h0B01);
        // reset in mid-run must drop the oscillator, run, slot and pin outputs and every register
        settle();
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        chk("ctrl_rst", 32'h0, {fast_en, slow_en, run_sel, slot_en});
        presetn <= 1'b1;
        all_zero();
        wrap_up();
    end
endmodule
